/* File: pkg/ocr_defs.svh */
// register offsets, field positions, reset values and timing figures of the output config bank
`ifndef OCR_DEFS_SVH
`define OCR_DEFS_SVH

`define OCR_ADDR_OFFSET 8'h10
`define OCR_ADDR_FORMAT 8'h14
`define OCR_ADDR_DRIVE 8'h15
`define OCR_ADDR_CLKPOL 8'h16
`define OCR_ADDR_CLKDLY 8'h17
`define OCR_ADDR_SPAN 8'h18
`define OCR_ADDR_PAT1_LO 8'h19
`define OCR_ADDR_PAT1_HI 8'h1a
`define OCR_ADDR_PAT2_LO 8'h1b
`define OCR_ADDR_PAT2_HI 8'h1c
`define OCR_ADDR_XFER 8'hff

`define OCR_BIT_OE_N 4
`define OCR_BIT_INVERT 2
`define OCR_BIT_CLK_FLIP 7
`define OCR_BIT_DLY_ON 7
`define OCR_BIT_XFER 0

`define OCR_RST_OFFSET 6'h00
`define OCR_RST_OE_N 1'h0
`define OCR_RST_INVERT 1'h0
`define OCR_RST_FMT 2'h1
`define OCR_RST_DRIVE 4'h1
`define OCR_RST_CLK_FLIP 1'h0
`define OCR_RST_DLY_ON 1'h0
`define OCR_RST_DLY_CODE 5'h00
`define OCR_RST_SPAN 5'h00
`define OCR_RST_PAT 16'h0000

`define OCR_FMT_OFFSET_BIN 2'h0
`define OCR_FMT_TWOS 2'h1

// data clock delay = span * code / max_code + base, in picoseconds
`define OCR_DLY_SPAN_PS 3100
`define OCR_DLY_MAX_CODE 31
`define OCR_DLY_BASE_PS 100

`endif

/* File: pkg/ocr_pkg.sv */
// types shared by the output config bank and its data path
`default_nettype none
package ocr_pkg;

  typedef struct packed {
    logic [5:0] offset;
    logic oe_n;
    logic invert;
    logic [1:0] fmt;
    logic [3:0] drive;
    logic clk_flip;
    logic dly_on;
    logic [4:0] dly_code;
    logic [4:0] span;
    logic [15:0] pat1;
    logic [15:0] pat2;
  } ocr_cfg_t;

  typedef struct packed {
    logic active;
    logic user;
    logic sel2;
  } ocr_test_t;

endpackage : ocr_pkg
`default_nettype wire

/* File: rtl/ocr_datapath.sv */
// output data path: offset trim, format, inversion and test override
`timescale 1ns/1ps
`default_nettype none
`include "ocr_defs.svh"

module ocr_datapath #(
  parameter int DATA_W = 14
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // active configuration and test select
  input wire ocr_pkg::ocr_cfg_t i_cfg,
  input wire ocr_pkg::ocr_test_t i_test,
  input wire logic [DATA_W-1:0] i_test_data,
  // converter samples, offset binary
  input wire logic [DATA_W-1:0] i_sample,
  // output pins
  output logic [DATA_W-1:0] o_data,
  output logic o_data_oe_n
);

  localparam logic [DATA_W:0] MAX_CODE = {1'b0, {DATA_W{1'b1}}};

  // signed sum one bit wider each way so both ends can be clamped
  wire logic signed [DATA_W+1:0] sum;
  wire logic [DATA_W-1:0] trimmed;
  wire logic [DATA_W-1:0] formatted;
  wire logic [DATA_W-1:0] user_word;
  wire logic [DATA_W-1:0] next_data;

  assign sum = $signed({2'b00, i_sample}) + (DATA_W+2)'($signed(i_cfg.offset));
  assign trimmed = sum[DATA_W+1] ? '0 :
                   (sum[DATA_W] ? MAX_CODE[DATA_W-1:0] : sum[DATA_W-1:0]);
  assign formatted = (i_cfg.fmt == `OCR_FMT_TWOS) ?
                     {~trimmed[DATA_W-1], trimmed[DATA_W-2:0]} : trimmed;
  // user words are left aligned: a narrower converter drops the low pattern bits
  assign user_word = i_test.sel2 ? i_cfg.pat2[15 -: DATA_W] : i_cfg.pat1[15 -: DATA_W];
  assign next_data = i_test.active ? (i_test.user ? user_word : i_test_data)
                     : (i_cfg.invert ? ~formatted : formatted);

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_data <= '0;
      o_data_oe_n <= 1'b1;
    end
    else
    begin
      o_data <= next_data;
      o_data_oe_n <= i_cfg.oe_n;
    end
  end

  AST_TEST_OVERRIDE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_test.active && i_test.user && !i_test.sel2 |=> o_data == $past(i_cfg.pat1[15 -: DATA_W]))
    else $error("user pattern not on data pins");
  AST_INVERT: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !i_test.active && i_cfg.invert |=> o_data == ~$past(formatted))
    else $error("inverted data mismatch");
  AST_FORMAT: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !i_test.active && !i_cfg.invert && i_cfg.fmt == `OCR_FMT_OFFSET_BIN |=>
    o_data == $past(trimmed))
    else $error("offset binary data mismatch");

endmodule : ocr_datapath
`default_nettype wire

/* File: rtl/ocr_regs.sv */
// output configuration register bank: holding stage, active stage, readback and data path
`timescale 1ns/1ps
`default_nettype none
`include "ocr_defs.svh"

// Function
// - format register bit 4 is active-low data output enable, reset on
// - format register bit 2 inverts every output data bit when set and no test mode is selected
// - delay register bit 7 enables the programmed data clock delay, reset off
// - delay code 4:0 gives 3100 ps times code over 31 plus 100 ps
// - five-bit two's complement span code, zero default, about 0.022 V per step
// - each 16-bit test word is a low byte and following high byte register
// - written values reach the active registers only on the transfer bit
// - a selected test mode puts test data or user words on the data pins
module ocr_regs #(
  parameter int DATA_W = 14
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // serial port register access, already decoded to bytes
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  // test mode select from the test control logic
  input wire ocr_pkg::ocr_test_t i_test,
  input wire logic [DATA_W-1:0] i_test_data,
  // converter samples, offset binary
  input wire logic [DATA_W-1:0] i_sample,
  // data pins
  output logic [DATA_W-1:0] o_data,
  output logic o_data_oe_n,
  // analog and clock output controls
  output logic o_clk_flip,
  output logic o_clk_delay_on,
  output logic [11:0] o_clk_delay_ps,
  output logic [4:0] o_span_code,
  output logic [3:0] o_drive_code
);

  // the pattern slice and the clamp need a data width of 8 to 16 bits
  if (DATA_W < 8 || DATA_W > 16)
  begin : g_width_check
    $error("ocr_regs: DATA_W must be 8 to 16");
  end

  localparam ocr_pkg::ocr_cfg_t CFG_RESET = '{
    offset: `OCR_RST_OFFSET, oe_n: `OCR_RST_OE_N, invert: `OCR_RST_INVERT,
    fmt: `OCR_RST_FMT, drive: `OCR_RST_DRIVE, clk_flip: `OCR_RST_CLK_FLIP,
    dly_on: `OCR_RST_DLY_ON, dly_code: `OCR_RST_DLY_CODE, span: `OCR_RST_SPAN,
    pat1: `OCR_RST_PAT, pat2: `OCR_RST_PAT};

  ocr_pkg::ocr_cfg_t shadow;
  ocr_pkg::ocr_cfg_t active;
  ocr_pkg::ocr_cfg_t next_shadow;

  // write and transfer decode
  wire logic wr_offset = i_wr_en && i_addr == `OCR_ADDR_OFFSET;
  wire logic wr_format = i_wr_en && i_addr == `OCR_ADDR_FORMAT;
  wire logic wr_drive = i_wr_en && i_addr == `OCR_ADDR_DRIVE;
  wire logic wr_clkpol = i_wr_en && i_addr == `OCR_ADDR_CLKPOL;
  wire logic wr_clkdly = i_wr_en && i_addr == `OCR_ADDR_CLKDLY;
  wire logic wr_span = i_wr_en && i_addr == `OCR_ADDR_SPAN;
  wire logic wr_p1lo = i_wr_en && i_addr == `OCR_ADDR_PAT1_LO;
  wire logic wr_p1hi = i_wr_en && i_addr == `OCR_ADDR_PAT1_HI;
  wire logic wr_p2lo = i_wr_en && i_addr == `OCR_ADDR_PAT2_LO;
  wire logic wr_p2hi = i_wr_en && i_addr == `OCR_ADDR_PAT2_HI;
  wire logic xfer = i_wr_en && i_addr == `OCR_ADDR_XFER && i_wr_data[`OCR_BIT_XFER];

  // only the defined bits are stored, so open bits cannot hold a written value
  always_comb
  begin
    next_shadow = shadow;
    if (wr_offset)
      next_shadow.offset = i_wr_data[5:0];
    if (wr_format)
    begin
      next_shadow.oe_n = i_wr_data[`OCR_BIT_OE_N];
      next_shadow.invert = i_wr_data[`OCR_BIT_INVERT];
      next_shadow.fmt = i_wr_data[1:0];
    end
    if (wr_drive)
      next_shadow.drive = i_wr_data[3:0];
    if (wr_clkpol)
      next_shadow.clk_flip = i_wr_data[`OCR_BIT_CLK_FLIP];
    if (wr_clkdly)
    begin
      next_shadow.dly_on = i_wr_data[`OCR_BIT_DLY_ON];
      next_shadow.dly_code = i_wr_data[4:0];
    end
    if (wr_span)
      next_shadow.span = i_wr_data[4:0];
    if (wr_p1lo)
      next_shadow.pat1[7:0] = i_wr_data;
    if (wr_p1hi)
      next_shadow.pat1[15:8] = i_wr_data;
    if (wr_p2lo)
      next_shadow.pat2[7:0] = i_wr_data;
    if (wr_p2hi)
      next_shadow.pat2[15:8] = i_wr_data;
  end

  // readback shows the holding stage so software can check before transferring
  wire logic [7:0] rd_mux =
    (i_addr == `OCR_ADDR_OFFSET) ? {2'h0, shadow.offset} :
    (i_addr == `OCR_ADDR_FORMAT) ? {3'h0, shadow.oe_n, 1'b0, shadow.invert, shadow.fmt} :
    (i_addr == `OCR_ADDR_DRIVE) ? {4'h0, shadow.drive} :
    (i_addr == `OCR_ADDR_CLKPOL) ? {shadow.clk_flip, 7'h00} :
    (i_addr == `OCR_ADDR_CLKDLY) ? {shadow.dly_on, 2'h0, shadow.dly_code} :
    (i_addr == `OCR_ADDR_SPAN) ? {3'h0, shadow.span} :
    (i_addr == `OCR_ADDR_PAT1_LO) ? shadow.pat1[7:0] :
    (i_addr == `OCR_ADDR_PAT1_HI) ? shadow.pat1[15:8] :
    (i_addr == `OCR_ADDR_PAT2_LO) ? shadow.pat2[7:0] :
    (i_addr == `OCR_ADDR_PAT2_HI) ? shadow.pat2[15:8] : 8'h00;

  // delay in ps; the product stays far below 32 bits
  wire logic [31:0] dly_full =
    32'(`OCR_DLY_SPAN_PS * int'(active.dly_code) / `OCR_DLY_MAX_CODE + `OCR_DLY_BASE_PS);
  wire logic [11:0] next_delay_ps = active.dly_on ? dly_full[11:0] : 12'h000;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      shadow <= CFG_RESET;
      active <= CFG_RESET;
    end
    else
    begin
      shadow <= next_shadow;
      if (xfer)
        active <= shadow;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_rd_data <= 8'h00;
      o_rd_valid <= 1'b0;
    end
    else
    begin
      o_rd_valid <= i_rd_en;
      o_rd_data <= i_rd_en ? rd_mux : 8'h00;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_clk_flip <= `OCR_RST_CLK_FLIP;
      o_clk_delay_on <= `OCR_RST_DLY_ON;
      o_clk_delay_ps <= 12'h000;
      o_span_code <= `OCR_RST_SPAN;
      o_drive_code <= `OCR_RST_DRIVE;
    end
    else
    begin
      o_clk_flip <= active.clk_flip;
      o_clk_delay_on <= active.dly_on;
      o_clk_delay_ps <= next_delay_ps;
      o_span_code <= active.span;
      o_drive_code <= active.drive;
    end
  end

  ocr_datapath #(
    .DATA_W(DATA_W)
  ) u_datapath (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_cfg(active),
    .i_test(i_test),
    .i_test_data(i_test_data),
    .i_sample(i_sample),
    .o_data(o_data),
    .o_data_oe_n(o_data_oe_n)
  );

  AST_HOLD_UNTIL_XFER: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !xfer |=> $stable(active))
    else $error("active registers changed without transfer");
  AST_XFER_COPY: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    xfer |=> active == $past(shadow))
    else $error("transfer did not copy holding stage");
  AST_OE_FOLLOWS: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    xfer ##1 1'b1 |=> o_data_oe_n == $past(active.oe_n))
    else $error("output enable does not follow register");
  AST_CLK_FLIP: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    xfer ##1 1'b1 |=> o_clk_flip == $past(active.clk_flip))
    else $error("data clock flip does not follow register");
  AST_DELAY_VALUE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    active.dly_on && active.dly_code == 5'h1f |=> o_clk_delay_ps == 12'hc80)
    else $error("full delay code not 3200 ps");
  AST_DELAY_OFF: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !active.dly_on |=> o_clk_delay_ps == 12'h000 && !o_clk_delay_on)
    else $error("delay applied while disabled");
  AST_SPAN: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    wr_span ##1 !wr_span ##1 xfer |=> ##1 o_span_code == $past(i_wr_data[4:0], 4))
    else $error("span code not delivered");
  AST_PAT_BYTES: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    wr_p1hi |=> shadow.pat1[15:8] == $past(i_wr_data) && $stable(shadow.pat1[7:0]))
    else $error("pattern high byte misplaced");
  AST_OPEN_ZERO: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_rd_en && i_addr == `OCR_ADDR_CLKPOL |=> o_rd_valid && o_rd_data[6:0] == 7'h00)
    else $error("open bits read nonzero");
  AST_OFFSET_TOP: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_rd_en && i_addr == `OCR_ADDR_OFFSET |=> o_rd_data[7:6] == 2'h0)
    else $error("offset upper bits nonzero");

  COV_XFER: cover property (@(posedge i_clk) disable iff (!i_reset_n) wr_format ##[1:4] xfer);
  COV_USER_PAT: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    i_test.active && i_test.user);
  COV_DELAY_ON: cover property (@(posedge i_clk) disable iff (!i_reset_n) o_clk_delay_on);
  COV_READ: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    i_rd_en && i_addr == `OCR_ADDR_PAT2_HI);

endmodule : ocr_regs
`default_nettype wire

/* File: verification/ocr_host.sv */
// serial host model that writes and reads the output config bank
`timescale 1ns/1ps
`default_nettype none
module ocr_host (
  // clock
  input wire logic i_clk,
  // register access toward the bank
  output logic o_wr_en,
  output logic o_rd_en,
  output logic [7:0] o_addr,
  output logic [7:0] o_wr_data,
  // read answer
  input wire logic [7:0] i_rd_data,
  input wire logic i_rd_valid
);
  initial
  begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 8'h00;
    o_wr_data = 8'h00;
  end
  // idle address and data show the inverse of the last value, never a stale copy
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_wr_en = 1'b1;
    o_addr = a;
    o_wr_data = d;
    @(negedge i_clk);
    o_wr_en = 1'b0;
    o_addr = ~a;
    o_wr_data = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge i_clk);
    o_rd_en = 1'b1;
    o_addr = a;
    @(negedge i_clk);
    o_rd_en = 1'b0;
    o_addr = ~a;
    d = i_rd_data;
    v = i_rd_valid;
  endtask : rd
  // staged values go live only on this write
  task automatic xfer();
    wr(8'hff, 8'h01);
  endtask : xfer
endmodule : ocr_host
`default_nettype wire

/* File: verification/ocr_regs_bench.sv */
// self-checking bench for the output config register bank
`timescale 1ns/1ps
`default_nettype none
module ocr_regs_bench;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic wr_en, rd_en, rd_valid, oe_n, flip, dly_on, vld;
  logic [7:0] addr, wr_data, rd_data, rv;
  logic [13:0] sample = '0;
  logic [13:0] tdata = '0;
  logic [13:0] data;
  logic [11:0] dly_ps;
  logic [4:0] span;
  logic [3:0] drive;
  ocr_pkg::ocr_test_t test = '0;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [7:0] av [10];
  logic [7:0] hv [10];
  // offsets, writable masks and reset values in table order
  logic [7:0] ra [10] = '{8'h10, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c};
  logic [7:0] rm [10] = '{8'h3f, 8'h17, 8'h0f, 8'h80, 8'h9f, 8'h1f, 8'hff, 8'hff, 8'hff, 8'hff};
  logic [7:0] rr [10] = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  ocr_host host (.i_clk(clk), .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr),
    .o_wr_data(wr_data), .i_rd_data(rd_data), .i_rd_valid(rd_valid));
  ocr_regs #(.DATA_W(14)) dut (.i_clk(clk), .i_reset_n(reset_n), .i_wr_en(wr_en),
    .i_rd_en(rd_en), .i_addr(addr), .i_wr_data(wr_data), .o_rd_data(rd_data),
    .o_rd_valid(rd_valid), .i_test(test), .i_test_data(tdata), .i_sample(sample),
    .o_data(data), .o_data_oe_n(oe_n), .o_clk_flip(flip), .o_clk_delay_on(dly_on),
    .o_clk_delay_ps(dly_ps), .o_span_code(span), .o_drive_code(drive));

  function automatic logic [13:0] exp_data(input logic [13:0] s);
    int sum;
    logic [13:0] r;
    sum = int'(s) + int'($signed(av[0][5:0]));
    if (sum < 0) sum = 0;
    if (sum > 16383) sum = 16383;
    r = sum[13:0];
    if (av[1][1:0] == 2'h1) r[13] = ~r[13];
    if (av[1][2]) r = ~r;
    // user words show their top bits on the narrower pins
    if (test.active) r = test.user ? (test.sel2 ? {av[9], av[8]} >> 2 : {av[7], av[6]} >> 2) : tdata;
    return r;
  endfunction : exp_data

  function automatic logic [11:0] exp_dly();
    return av[4][7] ? 12'((3100 * av[4][4:0]) / 31 + 100) : 12'h000;
  endfunction : exp_dly

  task automatic chk_reg(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk_reg

  task automatic chk_out(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk_out

  task automatic chk_cfg();
    chk_out("oe_n", 16'(av[1][4]), 16'(oe_n));
    chk_out("flip", 16'(av[3][7]), 16'(flip));
    chk_out("dly_on", 16'(av[4][7]), 16'(dly_on));
    chk_out("dly_ps", 16'(exp_dly()), 16'(dly_ps));
    chk_out("span", 16'(av[5][4:0]), 16'(span));
    chk_out("drive", 16'(av[2][3:0]), 16'(drive));
  endtask : chk_cfg

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  initial
  begin
    forever #20 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      finish_test();
    end
  end

  initial
  begin
    void'($urandom(32'h4c47));
    for (int i = 0; i < 10; i++) av[i] = rr[i];
    repeat (16) @(posedge clk);
    chk_out("oe_n_rst", 16'h0001, 16'(oe_n));
    chk_out("drive_rst", 16'h0001, 16'(drive));
    @(negedge clk) reset_n = 1'b1;
    for (int it = 0; it < 30; it++)
    begin
      // first pass writes all ones so open bits are exercised
      for (int i = 0; i < 10; i++)
      begin
        hv[i] = it == 0 ? 8'hff : 8'($urandom);
        host.wr(ra[i], hv[i]);
      end
      host.wr(8'hff, 8'h00);
      repeat (3) @(negedge clk);
      chk_cfg();
      // span rewritten just before the transfer so the span path is walked end to end
      host.wr(ra[5], hv[5]);
      host.xfer();
      for (int i = 0; i < 10; i++) av[i] = hv[i] & rm[i];
      for (int i = 0; i < 12; i++)
      begin
        host.rd(i < 10 ? ra[i] : (i == 10 ? 8'h11 : 8'hff), rv, vld);
        chk_reg("rd_data", i < 10 ? av[i] : 8'h00, rv);
        chk_reg("rd_valid", 8'h01, 8'(vld));
      end
      chk_cfg();
      for (int j = 0; j < 4; j++)
      begin
        @(negedge clk);
        sample = j == 0 ? 14'h0000 : (j == 1 ? 14'h3fff : 14'($urandom));
        test = j < 2 ? 3'h0 : 3'($urandom);
        tdata = 14'($urandom);
        @(negedge clk);
        chk_out("data", 16'(exp_data(sample)), 16'(data));
      end
      $display("test %0d done", it);
    end
    // a mid-run reset must bring every register and every configuration output back to its default
    @(negedge clk) reset_n = 1'b0;
    @(negedge clk) reset_n = 1'b1;
    for (int i = 0; i < 10; i++) av[i] = rr[i];
    repeat (2) @(negedge clk);
    chk_cfg();
    for (int i = 0; i < 10; i++)
    begin
      host.rd(ra[i], rv, vld);
      chk_reg("rd_rst", rr[i], rv);
    end
    $display("reset test done");
    finish_test();
  end
endmodule : ocr_regs_bench
`default_nettype wire
